// [rtl/dlc_defines.svh]
// Constants of the dual laser channel mode control block.
// Assumes the 50 MHz system clock.
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH

// ****************************************************************
// Register offsets (register index)
// ****************************************************************
`define DLC_ADDR_CH1_CTRL 8'h10
`define DLC_ADDR_CH2_CTRL 8'h15
`define DLC_ADDR_ADC_SEL 8'h1a
`define DLC_ADDR_MODE 8'h1b

// ****************************************************************
// Field positions
// ****************************************************************
`define DLC_BIT_LOOP_SEL 0
`define DLC_BIT_RES_BYPASS 2
`define DLC_BIT_CH_BLOCK 3
`define DLC_ADC_SRC_HI 7
`define DLC_ADC_SRC_LO 5
`define DLC_BIT_CH1_CURRENT_MEASURE_SEL 1
`define DLC_BIT_FNS1 2
`define DLC_BIT_CH2_CURRENT_MEASURE_SEL 5
`define DLC_BIT_FNS2 6

// ****************************************************************
// Reset values and mode register codes
// ****************************************************************
`define DLC_RST_CH_CTRL 8'h08
`define DLC_RST_ADC_SEL 8'h00
`define DLC_MODE_CONFIG 2'h2
`define DLC_MODE_OPER 2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define DLC_CLK_HZ 50000000
`define DLC_CFG_TIMEOUT_MS 40
`define DLC_CFG_TIMEOUT_CYC ((`DLC_CLK_HZ / 1000) * `DLC_CFG_TIMEOUT_MS)

`endif

// [rtl/dlc_pkg.sv]
// Types of the dual laser channel mode control block.
// Assumes nothing beyond the defines header.
package dlc_pkg;

	typedef enum logic [2:0] {
		DLC_ADC_OFF  = 3'h0,
		DLC_ADC_MON  = 3'h4,
		DLC_ADC_SUP  = 3'h5,
		DLC_ADC_LSUP = 3'h6,
		DLC_ADC_LOUT = 3'h7
	} dlc_adc_code_t;

	// Routed analog source, one-hot for the analog mux
	typedef enum logic [6:0] {
		DLC_SRC_NONE = 7'h01,
		DLC_SRC_SENS = 7'h02,
		DLC_SRC_MONP = 7'h04,
		DLC_SRC_ISNS = 7'h08,
		DLC_SRC_SUPP = 7'h10,
		DLC_SRC_LSUP = 7'h20,
		DLC_SRC_LOUT = 7'h40
	} dlc_src_t;

	typedef enum logic [1:0] {
		DLC_ST_OPER = 2'h1,
		DLC_ST_CFG  = 2'h2
	} dlc_state_t;

endpackage : dlc_pkg

// [rtl/dlc_chan.sv]
// One laser channel: enable gating with latched shutdown, ADC mux.
// Assumes synchronised pins and fault levels from the parent.
`timescale 1ns/1ns
`include "dlc_defines.svh"

module dlc_chan
	import dlc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       enable_pin,
	input  wire logic       block_bit,
	input  wire logic       host_mode,
	input  wire logic       cfg_fault,
	input  wire logic       supply_down,
	input  wire logic       trip,
	input  wire logic       timeout,
	input  wire logic [2:0] adc_src,
	input  wire logic       cmes,
	input  wire logic       fns,
	output logic            chan_on,
	output dlc_src_t        adc_route
);

	logic tripped_q;
	logic tripped_d;
	logic en_prev_q;
	logic en_prev_d;

	// Trip latch released only by a low enable pin
	always_comb begin
		en_prev_d = enable_pin;
		tripped_d = tripped_q;
		if (!enable_pin)
			tripped_d = 1'b0; // R09
		if (trip)
			tripped_d = 1'b1; // R09
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tripped_q <= 1'b0;
			en_prev_q <= 1'b0;
		end else begin
			tripped_q <= tripped_d;
			en_prev_q <= en_prev_d;
		end
	end

	// Source mux; code 100 refined by the two select bits
	always_comb begin
		unique case (adc_src)
			3'h4: begin
				if (cmes)
					adc_route = DLC_SRC_ISNS; // R15
				else if (fns)
					adc_route = DLC_SRC_MONP; // R16
				else
					adc_route = DLC_SRC_SENS; // R16
			end
			3'h5: adc_route = DLC_SRC_SUPP; // R14
			3'h6: adc_route = DLC_SRC_LSUP; // R14
			3'h7: adc_route = DLC_SRC_LOUT; // R14
			default: adc_route = DLC_SRC_NONE; // R14
		endcase
	end

	// Output gating; every shutdown wins over the pin
	assign chan_on = enable_pin & en_prev_q & ~tripped_q & ~trip
		& ~cfg_fault & ~supply_down & ~timeout
		& ~(host_mode & block_bit); // R06 R07 R08 R13

endmodule // dlc_chan

// [rtl/dlc_mode_ctrl.sv]
// Mode, channel enable and measurement select control, two channels.
// Assumes a register port from the serial interface decoder on clk,
// and asynchronous pins and analog comparator flags.
//
// What this block does
// (R01) Mode pin low gives standalone mode, no serial configuration.
// (R02) Standalone reference: supply minus 0.125 V or 0.250 V per pin.
// (R03) Standalone: both channels power loop, internal resistor off.
// (R04) Standalone: overcurrent threshold maximum; overcurrent stops own channel.
// (R05) System holds standby release pin high to leave standby.
// (R06) Channel on when its enable pin is high and no shutdown.
// (R07) Floating mode or interface pin blocks both channels.
// (R08) Supply power-down forces both channels off.
// (R09) Overcurrent or overtemperature latches off until enable pin cycles.
// (R10) Mode pin high gives microcontroller mode with serial configuration.
// (R11) Configuration writes shadow; switch to operation applies it.
// (R12) Configuration mode longer than 40 ms turns both channels off.
// (R13) Host mode: channel needs pin high and block bit zero.
// (R14) ADC source: 0xx off, 101 supply, 110 laser supply, 111 output.
// (R15) Code 100: current sensor when current bit set, else force/sense.
// (R16) Force/sense bits at 2 and 6 of shared register.
// (R17) Current-measure bits at 1 and 5 of shared register.
// (R18) Control bit 0: zero power loop, one current loop.
// (R19) Bypass bit 2 one removes internal monitor resistor.
// (R20) Host mode: interface pin high I2C, low SPI.
// (R21) Standby keeps all configuration contents.
// (R22) Configuration timer restarts on entry, stops in operation mode.
`timescale 1ns/1ns
`include "dlc_defines.svh"

module dlc_mode_ctrl
	import dlc_pkg::*;
#(
	parameter int unsigned CFG_TIMEOUT_CYC = `DLC_CFG_TIMEOUT_CYC
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       host_mode_pin,
	input  wire logic       host_mode_pin_open_fault,
	input  wire logic       iface_ref_select_pin,
	input  wire logic       iface_pin_open_fault,
	input  wire logic       standby_release_pin,
	input  wire logic       channel1_enable_pin,
	input  wire logic       channel2_enable_pin,
	input  wire logic       main_supply_down_fault,
	input  wire logic       core_supply_down_fault,
	input  wire logic [1:0] overcurrent_fault,
	input  wire logic       overtemp_fault,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	output logic            reg_ack,
	output logic            active_n,
	output logic            host_mode,
	output logic            i2c_select,
	output logic            ref_high_drop,
	output logic            ocp_max,
	output logic [1:0]      loop_current,
	output logic [1:0]      monitor_res_on,
	output logic [1:0]      channel_on,
	output dlc_src_t        adc_route1,
	output dlc_src_t        adc_route2,
	output logic            fault_indicator_pin
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Sync flops reset low, so pins read inactive for two cycles
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] pin_meta_q;
	logic [NSYNC-1:0] pin_sync_q;
	logic [NSYNC-1:0] pin_raw;

	// Overtemperature is folded into both trip lines here, so each
	// channel sees one trip input and latches it the same way
	assign pin_raw = {host_mode_pin, host_mode_pin_open_fault,
		iface_ref_select_pin, iface_pin_open_fault, standby_release_pin,
		channel1_enable_pin, channel2_enable_pin, main_supply_down_fault,
		core_supply_down_fault, overcurrent_fault[0] | overtemp_fault,
		overcurrent_fault[1] | overtemp_fault};

	// Two flops; only the second stage is used downstream
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	logic s_mode;
	logic s_mode_open;
	logic s_iref;
	logic s_iref_open;
	logic s_awake;
	logic s_en1;
	logic s_en2;
	logic s_vb_down;
	logic s_vdd_down;
	logic s_trip1;
	logic s_trip2;

	// Synchronised levels, in the order of pin_raw
	assign {s_mode, s_mode_open, s_iref, s_iref_open, s_awake, s_en1,
		s_en2, s_vb_down, s_vdd_down, s_trip1, s_trip2} = pin_sync_q;

	// ****************************************************************
	// Shadow and active configuration
	// ****************************************************************
	// Standby gates the channel outputs and refuses register access; no register reloads on wake (R21)
	logic [7:0] sh_ch1_q;
	logic [7:0] sh_ch2_q;
	logic [7:0] sh_adc_q;
	logic [7:0] act_ch1_q;
	logic [7:0] act_ch2_q;
	logic [7:0] act_adc_q;
	logic [7:0] sh_ch1_d;
	logic [7:0] sh_ch2_d;
	logic [7:0] sh_adc_d;
	logic [7:0] act_ch1_d;
	logic [7:0] act_ch2_d;
	logic [7:0] act_adc_d;
	dlc_state_t state_q;
	dlc_state_t state_d;

	// Address match, shared by write decode and readback
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// Decoded write strobes, mode register included
	logic wr_ok;
	logic go_oper;
	logic go_cfg;

	// Serial access exists only in host mode (R01 R10)
	assign wr_ok = reg_wr & s_mode & s_awake;
	assign go_oper = wr_ok & hit(reg_addr, `DLC_ADDR_MODE)
		& (reg_wdata[1:0] == `DLC_MODE_OPER);
	assign go_cfg = wr_ok & hit(reg_addr, `DLC_ADDR_MODE)
		& (reg_wdata[1:0] == `DLC_MODE_CONFIG);

	// Writes land in shadow; operation switch copies it across
	always_comb begin
		sh_ch1_d = sh_ch1_q;
		sh_ch2_d = sh_ch2_q;
		sh_adc_d = sh_adc_q;
		act_ch1_d = act_ch1_q;
		act_ch2_d = act_ch2_q;
		act_adc_d = act_adc_q;
		state_d = state_q;
		if (wr_ok && hit(reg_addr, `DLC_ADDR_CH1_CTRL))
			sh_ch1_d = reg_wdata; // R11
		if (wr_ok && hit(reg_addr, `DLC_ADDR_CH2_CTRL))
			sh_ch2_d = reg_wdata; // R11
		if (wr_ok && hit(reg_addr, `DLC_ADDR_ADC_SEL))
			sh_adc_d = reg_wdata; // R11
		unique case (state_q)
			DLC_ST_CFG: begin
				if (go_oper) begin
					state_d = DLC_ST_OPER;
					act_ch1_d = sh_ch1_q; // R11
					act_ch2_d = sh_ch2_q; // R11
					act_adc_d = sh_adc_q; // R11
				end
			end
			DLC_ST_OPER: begin
				if (go_cfg)
					state_d = DLC_ST_CFG;
			end
			default: state_d = DLC_ST_CFG;
		endcase
	end

	// Only srst reloads these; standby never touches them
	always_ff @(posedge clk) begin
		if (srst) begin
			sh_ch1_q <= `DLC_RST_CH_CTRL;
			sh_ch2_q <= `DLC_RST_CH_CTRL;
			sh_adc_q <= `DLC_RST_ADC_SEL;
			act_ch1_q <= `DLC_RST_CH_CTRL;
			act_ch2_q <= `DLC_RST_CH_CTRL;
			act_adc_q <= `DLC_RST_ADC_SEL;
			state_q <= DLC_ST_CFG;
		end else begin
			sh_ch1_q <= sh_ch1_d;
			sh_ch2_q <= sh_ch2_d;
			sh_adc_q <= sh_adc_d;
			act_ch1_q <= act_ch1_d;
			act_ch2_q <= act_ch2_d;
			act_adc_q <= act_adc_d;
			state_q <= state_d;
		end
	end

	// ****************************************************************
	// Configuration timeout
	// ****************************************************************
	// 32 bits hold the full 40 ms count at 50 MHz
	logic [31:0] cfg_cnt_q;
	logic [31:0] cfg_cnt_d;
	logic        tmo_q;
	logic        tmo_d;

	// Counter cleared on entry and kept at zero in operation mode
	always_comb begin
		cfg_cnt_d = cfg_cnt_q;
		tmo_d = tmo_q;
		if (!s_mode || state_q != DLC_ST_CFG || go_cfg) begin
			cfg_cnt_d = '0; // R22
			// Standalone has no configuration window, so no stale flag
			if (!s_mode || (state_q == DLC_ST_OPER && !go_cfg))
				tmo_d = 1'b0;
		end else if (cfg_cnt_q >= CFG_TIMEOUT_CYC - 1) begin
			tmo_d = 1'b1; // R12
		end else begin
			cfg_cnt_d = cfg_cnt_q + 32'h1; // R22
		end
	end

	// Timeout stays until operation mode is entered
	// or the mode pin selects standalone
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_cnt_q <= '0;
			tmo_q <= 1'b0;
		end else begin
			cfg_cnt_q <= cfg_cnt_d;
			tmo_q <= tmo_d;
		end
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************
	// Read data is registered and held until the next accepted read
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic       ack_q;

	// Readback shows the shadow, i.e. what software wrote
	// Mode reads: bit 1 in configuration, bit 2 timed out
	always_comb begin
		rdata_d = 8'h00;
		if (hit(reg_addr, `DLC_ADDR_CH1_CTRL))
			rdata_d = sh_ch1_q;
		else if (hit(reg_addr, `DLC_ADDR_CH2_CTRL))
			rdata_d = sh_ch2_q;
		else if (hit(reg_addr, `DLC_ADDR_ADC_SEL))
			rdata_d = sh_adc_q;
		else if (hit(reg_addr, `DLC_ADDR_MODE))
			rdata_d = {5'h00, tmo_q, state_q == DLC_ST_CFG, 1'b0};
	end

	// Ack only for accepted requests; a refused one stays silent,
	// so the host sees standby or standalone as a missing ack
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
			ack_q <= 1'b0;
		end else begin
			ack_q <= (reg_rd | reg_wr) & s_mode & s_awake;
			if (reg_rd && s_mode && s_awake)
				rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_ack = ack_q;

	// ****************************************************************
	// Mode outputs
	// ****************************************************************
	logic cfg_open;
	logic supply_dn;
	logic [1:0] blk;

	// Shutdown levels shared by both channels; standby counts as
	// supply loss since the drivers are unpowered then
	assign cfg_open = s_mode_open | s_iref_open; // R07
	assign supply_dn = s_vb_down | s_vdd_down | ~s_awake; // R08 R05
	assign host_mode = s_mode; // R01 R10
	assign active_n = ~s_awake; // R05
	assign i2c_select = s_mode & s_iref; // R20
	assign ref_high_drop = ~s_mode & s_iref; // R02
	assign ocp_max = ~s_mode; // R04
	// Standalone forces power loop and external resistor
	assign loop_current = s_mode ? {act_ch2_q[`DLC_BIT_LOOP_SEL],
		act_ch1_q[`DLC_BIT_LOOP_SEL]} : 2'h0; // R03 R18
	assign monitor_res_on = s_mode ? ~{act_ch2_q[`DLC_BIT_RES_BYPASS],
		act_ch1_q[`DLC_BIT_RES_BYPASS]} : 2'h0; // R03 R19
	// Block bits only count in host mode; gated inside the channel
	assign blk = {act_ch2_q[`DLC_BIT_CH_BLOCK], act_ch1_q[`DLC_BIT_CH_BLOCK]};
	// Open-drain style fault flag, driven low on any fault
	assign fault_indicator_pin = ~(cfg_open | supply_dn | s_trip1
		| s_trip2 | tmo_q);

	// ****************************************************************
	// Channels
	// ****************************************************************
	// Channel 1; ADC source forced off in standalone mode
	dlc_chan u_ch1 (
		.clk         (clk),
		.srst        (srst),
		.enable_pin  (s_en1),
		.block_bit   (blk[0]),
		.host_mode   (s_mode),
		.cfg_fault   (cfg_open),
		.supply_down (supply_dn),
		.trip        (s_trip1), // R04 R09
		.timeout     (tmo_q), // R12
		.adc_src     (s_mode ? act_ch1_q[`DLC_ADC_SRC_HI:`DLC_ADC_SRC_LO]
			: 3'h0),
		.cmes        (act_adc_q[`DLC_BIT_CH1_CURRENT_MEASURE_SEL]), // R17
		.fns         (act_adc_q[`DLC_BIT_FNS1]), // R16
		.chan_on     (channel_on[0]),
		.adc_route   (adc_route1)
	);

	// Channel 2; same gating, its own trip and enable
	dlc_chan u_ch2 (
		.clk         (clk),
		.srst        (srst),
		.enable_pin  (s_en2),
		.block_bit   (blk[1]),
		.host_mode   (s_mode),
		.cfg_fault   (cfg_open),
		.supply_down (supply_dn),
		.trip        (s_trip2), // R04 R09
		.timeout     (tmo_q), // R12
		.adc_src     (s_mode ? act_ch2_q[`DLC_ADC_SRC_HI:`DLC_ADC_SRC_LO]
			: 3'h0),
		.cmes        (act_adc_q[`DLC_BIT_CH2_CURRENT_MEASURE_SEL]), // R17
		.fns         (act_adc_q[`DLC_BIT_FNS2]), // R16
		.chan_on     (channel_on[1]),
		.adc_route   (adc_route2)
	);

endmodule // dlc_mode_ctrl

// [verif/dlc_props.sv]
// Port checker for the mode control block.
// Bound to dlc_mode_ctrl; one clock, sync reset srst.
`timescale 1ns/1ns
module dlc_props
	import dlc_pkg::*;
#(
	parameter int unsigned CFG_TIMEOUT_CYC = 50
) (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic       reg_ack,
	input wire logic       active_n,
	input wire logic       host_mode,
	input wire logic       i2c_select,
	input wire logic       ref_high_drop,
	input wire logic       ocp_max,
	input wire logic       iface_ref_select_pin,
	input wire logic       host_mode_pin_open_fault,
	input wire logic       main_supply_down_fault,
	input wire logic       core_supply_down_fault,
	input wire logic       channel1_enable_pin,
	input wire logic [1:0] overcurrent_fault,
	input wire logic [1:0] loop_current,
	input wire logic [1:0] monitor_res_on,
	input wire logic [1:0] channel_on,
	input wire logic       fault_indicator_pin
);
	// ********
	// Settle counter: pin sync flops hold zero for a while after reset
	// ********
	logic [1:0] up_q;
	logic [1:0] up_d;
	logic       rq;
	always_comb begin
		up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
	end
	always_ff @(posedge clk) begin
		up_q <= srst ? 2'h0 : up_d;
	end
	// Request that the port may take
	assign rq = (reg_wr || reg_rd) && host_mode && !active_n;

	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_ok;
		up_q == 2'h3;
	endsequence
	sequence s_trip;
		(overcurrent_fault[0] && channel1_enable_pin)[*4];
	endsequence
	sequence s_hold;
		channel1_enable_pin[*4];
	endsequence

	property p_ack;
		rq |=> reg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_noack;
		!rq |=> !reg_ack;
	endproperty
	a_noack: assert property (p_noack) else $error("stray ack");
	property p_sa;
		s_ok ##0 !host_mode |-> loop_current == 2'h0
			&& monitor_res_on == 2'h0 && ocp_max;
	endproperty
	a_sa: assert property (p_sa) else $error("standalone setup");
	property p_ref;
		s_ok ##0 $stable(iface_ref_select_pin)[*3] |->
			(host_mode ? i2c_select : ref_high_drop) == iface_ref_select_pin;
	endproperty
	a_ref: assert property (p_ref) else $error("ref or proto");
	property p_sup;
		(up_q == 2'h3 && (main_supply_down_fault || core_supply_down_fault))[*4]
			|-> channel_on == 2'h0 && !fault_indicator_pin;
	endproperty
	a_sup: assert property (p_sup) else $error("on in power down");
	property p_open;
		(up_q == 2'h3 && host_mode_pin_open_fault)[*4] |-> channel_on == 2'h0;
	endproperty
	a_open: assert property (p_open) else $error("on with open pin");
	property p_low;
		(up_q == 2'h3 && !channel1_enable_pin)[*4] |-> !channel_on[0];
	endproperty
	a_low: assert property (p_low) else $error("on with pin low");
	property p_trip;
		s_ok ##0 s_trip ##1 s_hold |-> !channel_on[0];
	endproperty
	a_trip: assert property (p_trip) else $error("trip not held");
endmodule // dlc_props

bind dlc_mode_ctrl dlc_props #(.CFG_TIMEOUT_CYC(CFG_TIMEOUT_CYC)) i_props (.*);

// [verif/dlc_host.sv]
// Host model: drives the decoded register port of the block.
// Assumes the serial decoder upstream; one-cycle strobes on clk.
`timescale 1ns/1ns
module dlc_host
	import dlc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reg_ack,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	// Idle port at time zero
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
	end
	// Strobe one cycle, then bounded wait; refusal gives ok low
	task automatic acc(input logic w, input logic [7:0] a, d,
		output logic [7:0] q, output logic ok);
		int n;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		{reg_wr, reg_rd} = 2'h0;
		reg_addr = ~a;
		reg_wdata = ~d;
		ok = 1'b0;
		for (n = 0; n < 3 && !ok; n++) begin
			@(posedge clk);
			ok = reg_ack;
			q = reg_rdata;
		end
		#1;
	endtask
endmodule // dlc_host

// [verif/testbench.sv]
// Self-checking bench for the mode control block.
// Assumes dlc_host drives the register port; clock 50 MHz.
`timescale 1ns/1ns
module testbench
	import dlc_pkg::*;
;
	localparam int unsigned TO = 50;
	logic clk, srst, host_mode_pin, host_mode_pin_open_fault;
	logic iface_ref_select_pin, iface_pin_open_fault, overtemp_fault;
	logic standby_release_pin, channel1_enable_pin, channel2_enable_pin;
	logic main_supply_down_fault, core_supply_down_fault;
	logic [1:0] overcurrent_fault, loop_current, monitor_res_on, channel_on;
	logic reg_wr, reg_rd, reg_ack, active_n, host_mode, i2c_select, ok;
	logic ref_high_drop, ocp_max, fault_indicator_pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q, c1, c2, s, pc1, pc2, ps;
	dlc_src_t adc_route1, adc_route2;
	int seed = 13;
	int n_errors = 0;
	int checks_done = 0;
	int i;

	dlc_mode_ctrl #(.CFG_TIMEOUT_CYC(TO)) i_dlc_mode_ctrl (.*);
	dlc_host i_dlc_host (.*);

	// ********
	// Clock, watchdog, helpers
	// ********
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Run needs about 600 cycles; give over thirty times that
	initial begin
		#400000;
		n_errors++;
		$display("MISMATCH t=%0t watchdog", $time);
		stop_test();
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [8:0] g, e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		i_dlc_host.acc(1'b1, a, d, q, ok);
		chk(ok, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, e);
		i_dlc_host.acc(1'b0, a, 8'h00, q, ok);
		chk({ok, q}, {1'b1, e});
	endtask
	function automatic dlc_src_t ex_rt(logic [7:0] c, logic cm, fs);
		case (c[7:5])
			3'h4: ex_rt = cm ? DLC_SRC_ISNS : fs ? DLC_SRC_MONP : DLC_SRC_SENS;
			3'h5: ex_rt = DLC_SRC_SUPP;
			3'h6: ex_rt = DLC_SRC_LSUP;
			3'h7: ex_rt = DLC_SRC_LOUT;
			default: ex_rt = DLC_SRC_NONE;
		endcase
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		{host_mode_pin_open_fault, iface_ref_select_pin} = 2'h0;
		{iface_pin_open_fault, main_supply_down_fault} = 2'h0;
		{core_supply_down_fault, overtemp_fault, overcurrent_fault} = 4'h0;
		{srst, host_mode_pin, standby_release_pin} = 3'h7;
		{channel1_enable_pin, channel2_enable_pin} = 2'h3;
		{pc1, pc2, ps} = {8'h08, 8'h08, 8'h00};
		tick(6);
		srst = 1'b0;
		tick(3);
		rd(8'h10, 8'h08);
		rd(8'h15, 8'h08);
		rd(8'h1a, 8'h00);
		rd(8'h3c, 8'h00);
		chk(channel_on, 2'h0);
		chk(i2c_select, iface_ref_select_pin);
		$display("reset test done");
		// Every source code on both channels, random other bits
		for (i = 0; i < 16; i++) begin
			c1 = {3'(i), 5'($random(seed)) & 5'h0d};
			c2 = {3'(i + 3), 5'($random(seed)) & 5'h0d};
			s = 8'($random(seed)) & 8'h66;
			{channel2_enable_pin, channel1_enable_pin} = 2'($random(seed));
			wr(8'h1b, 8'h02);
			wr(8'h10, c1);
			wr(8'h15, c2);
			wr(8'h1a, s);
			rd(8'h10, c1);
			rd(8'h1a, s);
			chk(adc_route1, ex_rt(pc1, ps[1], ps[2]));
			wr(8'h1b, 8'h00);
			tick(5);
			chk(channel_on, {channel2_enable_pin & !c2[3],
				channel1_enable_pin & !c1[3]});
			chk(loop_current, {c2[0], c1[0]});
			chk(monitor_res_on, {!c2[2], !c1[2]});
			chk(adc_route1, ex_rt(c1, s[1], s[2]));
			chk(adc_route2, ex_rt(c2, s[5], s[6]));
			{pc1, pc2, ps} = {c1, c2, s};
		end
		$display("register test done");
		{channel1_enable_pin, channel2_enable_pin} = 2'h3;
		wr(8'h1b, 8'h02);
		wr(8'h10, 8'h00);
		wr(8'h15, 8'h00);
		wr(8'h1b, 8'h00);
		tick(5);
		chk(channel_on, 2'h3);
		wr(8'h1b, 8'h02);
		tick(30);
		wr(8'h1b, 8'h02);
		tick(30);
		chk(channel_on, 2'h3);
		tick(30);
		chk(channel_on, 2'h0);
		rd(8'h1b, 8'h06);
		wr(8'h1b, 8'h00);
		tick(2);
		chk(channel_on, 2'h3);
		$display("timeout test done");
		// Trips latch until the pins cycle
		overcurrent_fault = 2'h1;
		tick(5);
		overcurrent_fault = 2'h0;
		tick(5);
		chk(channel_on, 2'h2);
		overtemp_fault = 1'b1;
		tick(5);
		overtemp_fault = 1'b0;
		tick(5);
		chk(channel_on, 2'h0);
		{channel1_enable_pin, channel2_enable_pin} = 2'h0;
		tick(5);
		{channel1_enable_pin, channel2_enable_pin} = 2'h3;
		tick(5);
		chk(channel_on, 2'h3);
		for (i = 1; i < 3; i++) begin
			{core_supply_down_fault, main_supply_down_fault} = 2'(i);
			tick(5);
			chk({channel_on, fault_indicator_pin}, 3'h0);
			{core_supply_down_fault, main_supply_down_fault} = 2'h0;
			tick(5);
			chk({channel_on, fault_indicator_pin}, 3'h7);
		end
		standby_release_pin = 1'b0;
		tick(5);
		chk({channel_on, active_n}, 3'h1);
		i_dlc_host.acc(1'b1, 8'h10, 8'h08, q, ok);
		chk(ok, 1'b0);
		standby_release_pin = 1'b1;
		tick(5);
		rd(8'h10, 8'h00);
		chk(channel_on, 2'h3);
		iface_ref_select_pin = 1'b1;
		tick(4);
		chk(i2c_select, 1'b1);
		$display("fault test done");
		// Standalone: pins rule, registers locked out
		host_mode_pin = 1'b0;
		tick(5);
		chk({host_mode, ocp_max}, 2'h1);
		chk({loop_current, monitor_res_on}, 4'h0);
		i_dlc_host.acc(1'b0, 8'h10, 8'h00, q, ok);
		chk(ok, 1'b0);
		for (i = 0; i < 2; i++) begin
			iface_ref_select_pin = i[0];
			tick(4);
			chk(ref_high_drop, i[0]);
		end
		overcurrent_fault = 2'h2;
		tick(5);
		overcurrent_fault = 2'h0;
		tick(3);
		chk(channel_on, 2'h1);
		{channel1_enable_pin, channel2_enable_pin} = 2'h0;
		tick(5);
		for (i = 0; i < 8; i++) begin
			{channel2_enable_pin, channel1_enable_pin} = 2'($random(seed));
			tick(5);
			chk(channel_on, {channel2_enable_pin, channel1_enable_pin});
		end
		for (i = 1; i < 3; i++) begin
			{iface_pin_open_fault, host_mode_pin_open_fault} = 2'(i);
			{channel2_enable_pin, channel1_enable_pin} = 2'h3;
			tick(5);
			chk({channel_on, fault_indicator_pin}, 3'h0);
		end
		$display("standalone test done");
		stop_test();
	end
endmodule // testbench
